// [rtl/crc_pkg.sv]
/*
 * Constants and carrier types for the conversion readout and calibration block.
 * Assumes one 125 MHz master clock and an external command decoder that
 * delivers decoded commands and register writes as one-cycle pulses.
 */
package crc_pkg;
    // ==========================================================
    // Widths, byte register indices, reset values
    // ==========================================================
    localparam int          RES_BITS   = 32;          // Result word width
    localparam logic [2:0]  REG_OFS0   = 3'h0;        // Offset bits 7..0
    localparam logic [2:0]  REG_OFS1   = 3'h1;        // Offset bits 15..8
    localparam logic [2:0]  REG_OFS2   = 3'h2;        // Offset bits 23..16
    localparam logic [2:0]  REG_GAIN0  = 3'h3;        // Gain bits 7..0
    localparam logic [2:0]  REG_GAIN1  = 3'h4;        // Gain bits 15..8
    localparam logic [2:0]  REG_GAIN2  = 3'h5;        // Gain bits 23..16
    localparam logic [23:0] OFS_RST    = 24'h000000;  // No offset correction
    localparam logic [23:0] GAIN_UNITY = 24'h400000;  // Gain of one
    localparam logic [23:0] GAIN_MAX   = 24'hffffff;  // Gain saturation
    localparam logic [31:0] POS_CLIP   = 32'h7fffffff;
    localparam logic [31:0] NEG_CLIP   = 32'h80000000;
    localparam logic [53:0] GAIN_NUM   = {32'h7ffffffe, 22'h0}; // Full scale times unity
    // ==========================================================
    // Timing counts
    // ==========================================================
    localparam logic [2:0]  HIGH_CYC   = 3'h4;        // Master clocks ready stays high on update
    localparam logic [4:0]  CAL_LAST   = 5'h0f;       // Sixteenth averaged result
    localparam logic [5:0]  DIV_LAST   = 6'h35;       // Fifty-fourth quotient step
    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } crc_sample_type;
    typedef struct packed {
        logic cont_read;
        logic stop_cont;
        logic read_data;
        logic standby;
        logic wakeup;
        logic cal_ofs;
        logic cal_gain;
    } crc_cmd_type;
    typedef struct packed {
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } crc_regwr_type;
endpackage

// [rtl/crc_top.sv]
/*
 * Conversion readout with offset and gain correction, result FIFO and
 * serial result shifter. Assumes filter results and decoded commands arrive
 * on the master clock, and the shift clock arrives asynchronously on a pin.
 */
// How it works
// - Results leave as 32-bit twos complement words
// - Unclipped FIR LSB repeats the sign bit
// - FIR overrange clips to 7FFFFFFFh or 80000000h
// - Sinc mode halves the output scale
// - Sinc mode never clips at half scale
// - Continuous read at reset and on command
// - Ready falling puts MSB on data out
// - First shift clock fall returns ready high
// - After 32 bits data out reads low
// - Stop command suppresses ready, conversions continue
// - One read command per result in command mode
// - Commanded data arrives within one data period
// - Subtract offset, then multiply by normalised gain
// - Words load by register write or calibration
// - Sinc mode bypasses correction
// - Offset is signed, left-justified before subtracting
// - Offset word resets to zero
// - Gain is straight binary, resets to unity
// - Each word spans three byte registers, low first
// - Calibration averages 16 results, writes word
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Result FIFO
// ==========================================================
module crc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        room;
    } crc_fifo_type;
    crc_fifo_type f_r, f_nxt;
    logic         push, pop;

    // Handshakes on both sides
    assign push      = in_valid & f_r.room;
    assign pop       = out_ready & out_valid;
    assign in_ready  = f_r.room;               // Space flag is a flop, so ready leaves a register
    assign out_valid = (f_r.cnt != '0);
    assign out_data  = f_r.mem[f_r.rp];

    // Pointer and count update
    always_comb begin
        f_nxt = f_r;
        if (push) begin
            f_nxt.mem[f_r.wp] = in_data;
            f_nxt.wp          = f_r.wp + 1'b1;
        end
        if (pop) begin
            f_nxt.rp = f_r.rp + 1'b1;
        end
        f_nxt.cnt  = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        f_nxt.room = (f_nxt.cnt != (AW+1)'(DEPTH));
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            f_r      <= '0;
            f_r.room <= 1'b1;
        end else begin
            f_r <= f_nxt;
        end
    end
endmodule

// ==========================================================
// Top: correction, calibration and serial readout
// ==========================================================
module crc_top
    import crc_pkg::*;
(
    input  wire logic          I_MCLK,
    input  wire logic          I_RST,
    input  wire logic          I_SCLK,
    input  wire crc_sample_type I_SAMPLE,
    output logic               O_SAMPLE_READY,
    input  wire logic          I_SINC_MODE,
    input  wire crc_cmd_type   I_CMD,
    input  wire crc_regwr_type I_REG,
    output logic [7:0]         O_REG_RDATA,
    output logic               O_DOUT,
    output logic               O_RESULT_READY_N
);
    typedef enum logic [2:0] {ST_IDLE, ST_CORR, ST_DIV, ST_PRESENT, ST_HOLD} crc_state_type;
    typedef struct packed {
        crc_state_type st;
        logic          sclk_s1;
        logic          sclk_s2;
        logic          sclk_d;
        logic [31:0]   x;
        logic [31:0]   res;
        logic [31:0]   shf;
        logic [5:0]    nbits;
        logic          rdy_n;
        logic [2:0]    hold;
        logic          cont;
        logic          rdreq;
        logic          standby;
        logic [23:0]   ofs;
        logic [23:0]   gain;
        logic [7:0]    rdata;
        logic          cal_ofs;
        logic          cal_gain;
        logic [4:0]    cal_cnt;
        logic [35:0]   sum;
        logic [53:0]   dq;
        logic [32:0]   rem;
        logic [31:0]   den;
        logic [5:0]    div_cnt;
    } crc_core_type;

    crc_core_type        s_r, s_nxt;
    logic                f_valid, f_pop, f_ready, fall, visible;
    logic [31:0]         f_data, fir;
    logic signed [31:0]  xs, ofs_lj;
    logic signed [32:0]  diff;
    logic signed [57:0]  prod, v;
    logic                sat_pos, sat_neg;
    logic [35:0]         sum_t;
    logic [32:0]         rem_t;
    logic [53:0]         dq_t;

    // Incoming results queue here while the sequencer is in correction, divide, present or hold
    crc_fifo #(.WIDTH(RES_BITS), .DEPTH(8)) u_fifo (
        .clk       (I_MCLK),
        .rst       (I_RST),
        .in_valid  (I_SAMPLE.valid),
        .in_data   (I_SAMPLE.data),
        .in_ready  (f_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_pop)
    );

    // Shift clock edge seen after two synchroniser stages
    assign fall    = s_r.sclk_d & ~s_r.sclk_s2;
    assign f_pop   = (s_r.st == ST_IDLE);
    assign visible = (s_r.cont | s_r.rdreq) & ~s_r.standby;

    // Offset subtract, gain multiply, saturate
    always_comb begin
        xs      = s_r.x;
        ofs_lj  = {s_r.ofs, 8'h00};
        diff    = 33'(xs) - 33'(ofs_lj);
        prod    = 58'(diff) * 58'(signed'({1'b0, s_r.gain}));
        v       = prod >>> 23;
        sat_pos = (v > 58'sh3fffffff) | (s_r.x == POS_CLIP);
        sat_neg = (v < -58'sh40000000) | (s_r.x == NEG_CLIP);
        if (sat_pos) begin
            fir = POS_CLIP;
        end else if (sat_neg) begin
            fir = NEG_CLIP;
        end else begin
            fir = {v[30:0], v[30]};
        end
    end

    // Sequencer, calibration, divider, shifter and register access
    always_comb begin
        s_nxt   = s_r;
        sum_t   = s_r.sum + (s_r.cal_ofs ? 36'(xs) : 36'(diff));
        rem_t   = {s_r.rem[31:0], s_r.dq[53]};
        dq_t    = {s_r.dq[52:0], 1'b0};
        s_nxt.sclk_s1 = I_SCLK;
        s_nxt.sclk_s2 = s_r.sclk_s1;
        s_nxt.sclk_d  = s_r.sclk_s2;
        if (fall) begin
            s_nxt.shf   = {s_r.shf[30:0], 1'b0};
            s_nxt.nbits = (s_r.nbits == 6'h20) ? s_r.nbits : s_r.nbits + 1'b1;
            s_nxt.rdy_n = 1'b1;
        end
        case (s_r.st)
            ST_IDLE: begin
                if (f_valid) begin
                    s_nxt.x  = f_data;
                    s_nxt.st = ST_CORR;
                end
            end
            ST_CORR: begin
                s_nxt.res = I_SINC_MODE ? {s_r.x[31], s_r.x[31:1]} : fir;
                s_nxt.st  = ST_PRESENT;
                if ((s_r.cal_ofs | s_r.cal_gain) & ~I_SINC_MODE) begin
                    s_nxt.sum     = sum_t;
                    s_nxt.cal_cnt = s_r.cal_cnt + 1'b1;
                    if (s_r.cal_cnt == CAL_LAST) begin
                        s_nxt.cal_ofs  = 1'b0;
                        s_nxt.cal_gain = 1'b0;
                        if (s_r.cal_ofs) begin
                            s_nxt.ofs = sum_t[35:12];
                        end else if (!sum_t[35] && sum_t[35:4] != '0) begin
                            s_nxt.den     = sum_t[35:4];
                            s_nxt.dq      = GAIN_NUM;
                            s_nxt.rem     = '0;
                            s_nxt.div_cnt = '0;
                            s_nxt.st      = ST_DIV;
                        end
                    end
                end
            end
            ST_DIV: begin
                if (rem_t >= {1'b0, s_r.den}) begin
                    rem_t   = rem_t - {1'b0, s_r.den};
                    dq_t[0] = 1'b1;
                end
                s_nxt.rem     = rem_t;
                s_nxt.dq      = dq_t;
                s_nxt.div_cnt = s_r.div_cnt + 1'b1;
                if (s_r.div_cnt == DIV_LAST) begin
                    s_nxt.gain = (|dq_t[53:24]) ? GAIN_MAX : dq_t[23:0];
                    s_nxt.st   = ST_PRESENT;
                end
            end
            ST_PRESENT: begin
                if (!visible) begin
                    s_nxt.st = ST_IDLE;
                end else if (!s_r.rdy_n && !fall) begin
                    s_nxt.rdy_n = 1'b1;
                    s_nxt.hold  = HIGH_CYC - 1'b1;
                    s_nxt.st    = ST_HOLD;
                end else begin
                    s_nxt.shf   = s_r.res;
                    s_nxt.nbits = '0;
                    s_nxt.rdy_n = 1'b0;
                    s_nxt.rdreq = 1'b0;
                    s_nxt.st    = ST_IDLE;
                end
            end
            ST_HOLD: begin
                s_nxt.hold = s_r.hold - 1'b1;
                if (!visible) begin
                    s_nxt.st = ST_IDLE;
                end else if (s_r.hold == '0) begin
                    s_nxt.shf   = s_r.res;
                    s_nxt.nbits = '0;
                    s_nxt.rdy_n = 1'b0;
                    s_nxt.rdreq = 1'b0;
                    s_nxt.st    = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        // Commands come last so a new request beats a same-cycle clear
        if (I_CMD.cont_read) begin
            s_nxt.cont = 1'b1;
        end
        if (I_CMD.stop_cont) begin
            s_nxt.cont = 1'b0;
        end
        if (I_CMD.read_data) begin
            s_nxt.rdreq = 1'b1;
        end
        if (I_CMD.standby) begin
            s_nxt.standby = 1'b1;
        end
        if (I_CMD.wakeup) begin
            s_nxt.standby = 1'b0;
        end
        if (I_CMD.cal_ofs | I_CMD.cal_gain) begin
            s_nxt.cal_ofs  = I_CMD.cal_ofs;
            s_nxt.cal_gain = I_CMD.cal_gain & ~I_CMD.cal_ofs;
            s_nxt.cal_cnt  = '0;
            s_nxt.sum      = '0;
        end
        // Byte registers, low byte at the lowest index
        if (I_REG.wr) begin
            case (I_REG.addr)
                REG_OFS0:  s_nxt.ofs[7:0]    = I_REG.wdata;
                REG_OFS1:  s_nxt.ofs[15:8]   = I_REG.wdata;
                REG_OFS2:  s_nxt.ofs[23:16]  = I_REG.wdata;
                REG_GAIN0: s_nxt.gain[7:0]   = I_REG.wdata;
                REG_GAIN1: s_nxt.gain[15:8]  = I_REG.wdata;
                REG_GAIN2: s_nxt.gain[23:16] = I_REG.wdata;
                default:   s_nxt.ofs         = s_nxt.ofs;
            endcase
        end
        case (I_REG.addr)
            REG_OFS0:  s_nxt.rdata = s_r.ofs[7:0];
            REG_OFS1:  s_nxt.rdata = s_r.ofs[15:8];
            REG_OFS2:  s_nxt.rdata = s_r.ofs[23:16];
            REG_GAIN0: s_nxt.rdata = s_r.gain[7:0];
            REG_GAIN1: s_nxt.rdata = s_r.gain[15:8];
            REG_GAIN2: s_nxt.rdata = s_r.gain[23:16];
            default:   s_nxt.rdata = 8'h00;
        endcase
    end

    // State register with constant reset values
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            s_r       <= '0;
            s_r.ofs   <= OFS_RST;
            s_r.gain  <= GAIN_UNITY;
            s_r.rdy_n <= 1'b1;
            s_r.cont  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign O_DOUT           = s_r.shf[31];
    assign O_RESULT_READY_N = s_r.rdy_n;
    assign O_REG_RDATA      = s_r.rdata;
    assign O_SAMPLE_READY   = f_ready;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    a_fir_clip_pos: assert property (s_r.st == ST_CORR && !I_SINC_MODE && sat_pos |=> s_r.res == POS_CLIP)
        else $error("positive overrange not clipped");
    a_lsb_sign: assert property (s_r.st == ST_CORR && !I_SINC_MODE && !sat_pos && !sat_neg
        |=> s_r.res[0] == s_r.res[31])
        else $error("redundant sign bit wrong");
    a_sinc_half: assert property (s_r.st == ST_CORR && I_SINC_MODE
        |=> s_r.res[30:0] == $past(s_r.x[31:1]) && s_r.res[31] == $past(s_r.x[31]))
        else $error("sinc result not halved");
    a_ready_rise: assert property (fall && !s_r.rdy_n |=> s_r.rdy_n)
        else $error("ready not released on shift fall");
    a_dout_low: assert property (s_r.nbits == 6'h20 |-> !O_DOUT)
        else $error("data out not low after 32 bits");
    a_ready_gated: assert property ($fell(s_r.rdy_n) |-> $past(visible))
        else $error("ready fell while suppressed");
    a_msb_loaded: assert property ($fell(s_r.rdy_n) |-> s_r.shf == s_r.res)
        else $error("result not on shifter at ready fall");
    a_update_high: assert property (s_r.st == ST_PRESENT && visible && !s_r.rdy_n && !fall
        |=> s_r.rdy_n [*4] ##1 !s_r.rdy_n)
        else $error("ready high pulse not four clocks");
    a_gain_write: assert property (I_REG.wr && I_REG.addr == REG_GAIN2 && s_r.st != ST_DIV
        |=> s_r.gain[23:16] == $past(I_REG.wdata))
        else $error("gain high byte not written");
    a_cmd_once: assert property (!s_r.cont && $fell(s_r.rdy_n) |-> !s_r.rdreq || $past(I_CMD.read_data))
        else $error("read request not consumed");

    c_cont_read: cover property (s_r.cont && $fell(s_r.rdy_n));
    c_cmd_read: cover property (!s_r.cont && $fell(s_r.rdy_n));
    c_ofs_cal: cover property (s_r.cal_ofs ##1 !s_r.cal_ofs);
    c_gain_div: cover property (s_r.st == ST_DIV && s_r.div_cnt == DIV_LAST);
endmodule
`default_nettype wire

// [tb/crc_host_model.sv]
/*
 * Host controller model that shifts results out of the serial readout port.
 * Assumes it is paced by the master clock and that the shift clock idles low.
 */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Host controller model
// ==========================================================
module crc_host_model (
    input  wire logic i_clk,
    input  wire logic i_dout,
    input  wire logic i_ready_n,
    output logic      o_sclk
);
    initial o_sclk = 1'b0;
    // Waits for ready low, clocks nbits out at 160 ns; flags ready and tail faults
    task automatic read_word(input int nbits, output logic [31:0] w, output logic ok);
        w = 32'h0;
        ok = 1'b0;
        for (int t = 0; t < 400 && i_ready_n !== 1'b0; t++) @(posedge i_clk);
        if (i_ready_n !== 1'b0) return;
        ok = 1'b1;
        for (int i = 0; i < nbits; i++) begin
            repeat (10) @(posedge i_clk);
            o_sclk <= 1'b1;
            w = {w[30:0], i_dout};
            if (i == 1 && i_ready_n !== 1'b1) ok = 1'b0;
            repeat (10) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (10) @(posedge i_clk);
        if (nbits == 32 && i_dout !== 1'b0) ok = 1'b0;
        // Short read leaves the word left-justified
        if (nbits < 32) w = w << (32 - nbits);
    endtask
endmodule
`default_nettype wire

// [tb/test_conversion_readout_calibration.sv]
/*
 * Self-checking bench for the readout and calibration block.
 * Assumes the package constants and the host model beside it.
 */
`timescale 1ns/10ps
`default_nettype none
module test_conversion_readout_calibration
    import crc_pkg::*;
;
    logic           mclk = 1'b0;
    logic           rst = 1'b1;
    logic           sclk;
    crc_sample_type smp = '0;
    logic           smp_rdy;
    logic           sinc = 1'b0;
    crc_cmd_type    cmd = '0;
    crc_regwr_type  regw = '0;
    logic [7:0]     rdata;
    logic           dout;
    logic           rdy_n;
    logic           full;
    int             n_errors = 0;
    int             num_checks = 0;
    int             cycles = 0;
    logic [23:0]    ofs = OFS_RST;
    logic [23:0]    gain = GAIN_UNITY;
    // ==========================================================
    // Clock, design and host
    // ==========================================================
    always #4 mclk = ~mclk;
    crc_top uut (.I_MCLK(mclk), .I_RST(rst), .I_SCLK(sclk), .I_SAMPLE(smp), .O_SAMPLE_READY(smp_rdy),
        .I_SINC_MODE(sinc), .I_CMD(cmd), .I_REG(regw), .O_REG_RDATA(rdata), .O_DOUT(dout),
        .O_RESULT_READY_N(rdy_n));
    crc_host_model host (.i_clk(mclk), .i_dout(dout), .i_ready_n(rdy_n), .o_sclk(sclk));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Expected FIR output from current offset and gain
    function automatic logic [31:0] fir_exp(input logic [31:0] raw);
        longint p;
        p = ((longint'($signed(raw)) - longint'($signed(ofs)) * 256) * longint'(gain)) >>> 22;
        if (raw == POS_CLIP || p > 64'sh7fffffff) return POS_CLIP;
        if (raw == NEG_CLIP || p < -64'sh80000000) return NEG_CLIP;
        return {p[31:1], p[63]};
    endfunction
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk) regw <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge mclk) regw.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk) regw.addr <= a;
        repeat (2) @(posedge mclk);
        @(negedge mclk) check("register byte", {24'h0, exp}, {24'h0, rdata});
    endtask
    task automatic set_cal(input logic [23:0] o, input logic [23:0] g);
        ofs = o;
        gain = g;
        for (int i = 0; i < 3; i++) begin
            wr(REG_OFS0 + 3'(i), o[8*i +: 8]);
            wr(REG_GAIN0 + 3'(i), g[8*i +: 8]);
        end
        rd(REG_OFS2, o[23:16]);
        rd(REG_GAIN0, g[7:0]);
    endtask
    task automatic pulse(input crc_cmd_type c);
        @(posedge mclk) cmd <= c;
        @(posedge mclk) cmd <= '0;
    endtask
    // Holds valid until n rising edges see ready high
    task automatic burst(input logic [31:0] d, input int n, output logic saw_full);
        int got;
        got = 0;
        saw_full = 1'b0;
        @(posedge mclk) smp <= '{valid: 1'b1, data: d};
        while (got < n) begin
            @(negedge mclk);
            if (smp_rdy !== 1'b1) saw_full = 1'b1;
            else got++;
            @(posedge mclk);
        end
        smp.valid <= 1'b0;
    endtask
    task automatic read_chk(input int nb, input logic [31:0] exp, input string what);
        logic [31:0] w;
        logic        ok;
        host.read_word(nb, w, ok);
        check({what, " ready and tail"}, 32'h1, {31'h0, ok});
        check(what, exp, w);
    endtask
    // Push one result and read it back whole
    task automatic one(input logic [31:0] raw, input logic [31:0] exp, input string what);
        logic f;
        burst(raw, 1, f);
        read_chk(32, exp, what);
    endtask
    task automatic quiet(input int n, input string what);
        logic seen;
        seen = 1'b0;
        repeat (n) @(negedge mclk) if (rdy_n !== 1'b1) seen = 1'b1;
        check(what, 32'h0, {31'h0, seen});
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs();
        rd(REG_OFS0, 8'h00);
        rd(REG_OFS1, 8'h00);
        rd(REG_OFS2, 8'h00);
        rd(REG_GAIN0, 8'h00);
        rd(REG_GAIN1, 8'h00);
        rd(REG_GAIN2, 8'h40);
        wr(3'h6, 8'h5a);
        rd(3'h6, 8'h00);
        rd(3'h7, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_cont();
        one(32'h12345678, fir_exp(32'h12345678), "positive word");
        one(32'hffffff00, fir_exp(32'hffffff00), "negative word");
        burst(32'h2468ace0, 1, full);
        read_chk(24, fir_exp(32'h2468ace0) & 32'hffffff00, "short read");
        one(32'h00000100, fir_exp(32'h00000100), "after short read");
        $display("test continuous done");
    endtask
    task automatic t_clip();
        one(32'h7fffffff, fir_exp(32'h7fffffff), "positive clip");
        one(32'h80000000, fir_exp(32'h80000000), "negative clip");
        one(32'h80000001, fir_exp(32'h80000001), "negative full scale");
        one(32'h7ffffffe, fir_exp(32'h7ffffffe), "positive full scale");
        set_cal(24'h000001, GAIN_UNITY);
        one(32'h00001000, fir_exp(32'h00001000), "offset one");
        set_cal(24'h800000, GAIN_UNITY);
        one(32'h10000000, fir_exp(32'h10000000), "offset saturates high");
        set_cal(24'h7fffff, GAIN_UNITY);
        one(32'h80000100, fir_exp(32'h80000100), "offset saturates low");
        set_cal(OFS_RST, 24'h800000);
        one(32'h00001000, fir_exp(32'h00001000), "gain two");
        one(32'h60000000, fir_exp(32'h60000000), "gain saturates");
        set_cal(OFS_RST, 24'h200000);
        one(32'h00001000, fir_exp(32'h00001000), "gain half");
        $display("test correction done");
    endtask
    task automatic t_sinc();
        set_cal(24'h000100, 24'h800000);
        @(posedge mclk) sinc <= 1'b1;
        one(32'h7ffffffe, 32'h3fffffff, "sinc positive");
        one(32'h80000001, 32'hc0000000, "sinc negative");
        one(32'h7fffffff, 32'h3fffffff, "sinc over high");
        one(32'h80000000, 32'hc0000000, "sinc over low");
        @(posedge mclk) sinc <= 1'b0;
        set_cal(OFS_RST, GAIN_UNITY);
        $display("test sinc done");
    endtask
    task automatic t_cmd();
        pulse('{stop_cont: 1'b1, default: 1'b0});
        burst(32'h11110000, 1, full);
        quiet(60, "ready after stop");
        pulse('{read_data: 1'b1, default: 1'b0});
        one(32'h22220000, fir_exp(32'h22220000), "read by command");
        burst(32'h33330000, 1, full);
        quiet(60, "one result per command");
        pulse('{cont_read: 1'b1, default: 1'b0});
        one(32'h44440000, fir_exp(32'h44440000), "continuous again");
        $display("test command mode done");
    endtask
    task automatic t_oneshot();
        pulse('{standby: 1'b1, default: 1'b0});
        burst(32'h55550000, 1, full);
        quiet(60, "ready in standby");
        pulse('{wakeup: 1'b1, default: 1'b0});
        one(32'h66660000, fir_exp(32'h66660000), "one shot");
        pulse('{standby: 1'b1, default: 1'b0});
        pulse('{wakeup: 1'b1, default: 1'b0});
        $display("test one shot done");
    endtask
    task automatic t_fifo();
        burst(32'h01010000, 12, full);
        check("fifo refused when full", 32'h1, {31'h0, full});
        repeat (200) @(posedge mclk);
        @(negedge mclk) check("fifo drained", 32'h1, {31'h0, smp_rdy});
        read_chk(32, fir_exp(32'h01010000), "last queued");
        $display("test fifo done");
    endtask
    task automatic t_cal();
        pulse('{cal_ofs: 1'b1, default: 1'b0});
        burst(32'h00123400, 16, full);
        repeat (300) @(posedge mclk);
        rd(REG_OFS0, 8'h34);
        rd(REG_OFS1, 8'h12);
        rd(REG_OFS2, 8'h00);
        set_cal(OFS_RST, GAIN_UNITY);
        pulse('{cal_gain: 1'b1, default: 1'b0});
        burst(32'h40000000, 16, full);
        repeat (300) @(posedge mclk);
        rd(REG_GAIN0, 8'hff);
        rd(REG_GAIN2, 8'h7f);
        $display("test calibration done");
    endtask
    // ==========================================================
    // Main sequence and run-time limit
    // ==========================================================
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            $display("BAD run time expected done seen timeout");
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_cont();
        t_clip();
        t_sinc();
        t_cmd();
        t_oneshot();
        t_fifo();
        t_cal();
        tally_and_finish();
    end
endmodule
`default_nettype wire
